// [include/can_mode_pkg.sv]
// Shared constants and types for the mode, timestamp and bit-timing block
package can_mode_pkg;
    // Clock and bus rate range
    localparam int CLK_HZ = 20_000_000;
    localparam int MIN_RATE_BPS = 10_000;
    localparam int MAX_RATE_BPS = 1_000_000;
    localparam int PRESC_W_DEF = 7;
    // Segment limits in time quanta
    localparam int SYNC_SEG_TQ = 1;
    localparam int SEG1_MIN_TQ = 4;
    localparam int SEG1_MAX_TQ = 16;
    localparam int SEG2_MIN_TQ = 2;
    localparam int SEG2_MAX_TQ = 8;
    localparam int SJW_MIN_TQ = 1;
    localparam int SJW_MAX_TQ = 4;
    localparam int SEG1_FIELD_W = 4;
    localparam int SEG2_FIELD_W = 3;
    localparam int SJW_FIELD_W = 2;
    localparam int TQ_CNT_W = 5;
    // Bus idle and recovery counts
    localparam int IDLE_RUN_BITS = 11;
    localparam int BUSOFF_SEQS = 128;
    // Wake-up glitch filter: least dominant time, rounded up
    localparam int WAKE_FILTER_NS = 2000;
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Capture channels of the timestamp link
    localparam int TS_CH_FIRST = 4;
    localparam int TS_CH_SECOND = 5;
    localparam logic RECESSIVE = 1'b1;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_SLEEP_PEND = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_WAKE_SYNC = 3'b011,
        MODE_SOFT_RESET = 3'b100,
        MODE_POWER_DOWN = 3'b101
    } mode_e;

    typedef enum logic [1:0] {
        SEG_SYNC = 2'b00,
        SEG_ONE = 2'b01,
        SEG_TWO = 2'b10
    } seg_e;

    // Field value plus one gives the length in quanta
    function automatic logic [TQ_CNT_W-1:0] field_len(input logic [3:0] f);
        field_len = {1'b0, f} + 5'h01;
    endfunction : field_len
endpackage : can_mode_pkg

// [logic/bit_timing_unit.sv]
// Bit time segmentation with resynchronisation
`timescale 1ns/100ps
module bit_timing_unit (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic tq_tick_i,
    input wire logic rx_i,
    input wire logic hard_sync_i,
    input wire logic [can_mode_pkg::SEG1_FIELD_W-1:0] seg1_field_i,
    input wire logic [can_mode_pkg::SEG2_FIELD_W-1:0] seg2_field_i,
    input wire logic [can_mode_pkg::SJW_FIELD_W-1:0] sjw_field_i,
    output logic bit_start_o,
    output logic sample_o
);
    import can_mode_pkg::*;

    seg_e seg;
    logic [TQ_CNT_W-1:0] cnt;
    logic [TQ_CNT_W-1:0] lim;
    logic [TQ_CNT_W-1:0] jump_width_field;
    logic [TQ_CNT_W-1:0] ext;
    logic [TQ_CNT_W-1:0] next_lim;
    logic rx_prev;
    logic edge_seen;

    // Recessive to dominant edge seen at a quantum boundary
    assign edge_seen = rx_prev & ~rx_i;
    assign jump_width_field = field_len({2'b00, sjw_field_i});
    assign ext = (cnt < jump_width_field) ? cnt : jump_width_field;

    // Limit of the running segment after any phase correction
    always_comb begin
        next_lim = lim;
        if (edge_seen && seg == SEG_ONE) begin
            next_lim = lim + ext;
        end else if (edge_seen && seg == SEG_TWO) begin
            next_lim = lim - jump_width_field;
        end
    end

    // Segment sequencer, one step per quantum
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seg <= SEG_SYNC;
            cnt <= '0;
            lim <= '0;
            rx_prev <= 1'b1;
            bit_start_o <= 1'b0;
            sample_o <= 1'b0;
        end else begin
            bit_start_o <= 1'b0;
            sample_o <= 1'b0;
            if (!run_i) begin
                seg <= SEG_SYNC;
                cnt <= '0;
                rx_prev <= 1'b1;
            end else if (tq_tick_i) begin
                rx_prev <= rx_i;
                if (hard_sync_i) begin
                    seg <= SEG_ONE;
                    cnt <= 5'h01;
                    lim <= field_len(seg1_field_i);
                    bit_start_o <= 1'b1;
                end else begin
                    case (seg)
                        SEG_SYNC: begin
                            // Sync segment lasts one quantum
                            seg <= SEG_ONE;
                            cnt <= 5'h01;
                            lim <= field_len(seg1_field_i);
                        end
                        SEG_ONE: begin
                            if (cnt >= next_lim) begin
                                seg <= SEG_TWO;
                                cnt <= 5'h01;
                                lim <= field_len({1'b0, seg2_field_i});
                                sample_o <= 1'b1;
                            end else begin
                                cnt <= cnt + 5'h01;
                                lim <= next_lim;
                            end
                        end
                        SEG_TWO: begin
                            if (edge_seen && (lim - cnt) <= jump_width_field) begin
                                // Edge acts as the next sync segment
                                seg <= SEG_ONE;
                                cnt <= 5'h01;
                                lim <= field_len(seg1_field_i);
                                bit_start_o <= 1'b1;
                            end else if (cnt >= next_lim) begin
                                seg <= SEG_SYNC;
                                bit_start_o <= 1'b1;
                            end else begin
                                cnt <= cnt + 5'h01;
                                lim <= next_lim;
                            end
                        end
                        default: begin
                            seg <= SEG_SYNC;
                        end
                    endcase
                end
            end
        end
    end
endmodule : bit_timing_unit

// [logic/can_mode_timestamp_bit_timing.sv]
// Operating modes, timestamp link and bit timing of the bus controller
`timescale 1ns/100ps
module can_mode_timestamp_bit_timing #(
    parameter int PRESC_W = can_mode_pkg::PRESC_W_DEF,
    parameter bit HAS_CLOCK_GEN = 1'b1,
    parameter int CONTROLLER_INDEX = 0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic soft_reset_request_bit_i,
    input wire logic sleep_request_bit_i,
    input wire logic stop_in_wait_bit_i,
    input wire logic wakeup_filter_select_i,
    input wire logic timestamp_link_enable_i,
    input wire logic clock_origin_select_i,
    input wire logic [PRESC_W-1:0] prescaler_field_i,
    input wire logic [can_mode_pkg::SEG1_FIELD_W-1:0] first_phase_length_field_i,
    input wire logic [can_mode_pkg::SEG2_FIELD_W-1:0] second_phase_length_field_i,
    input wire logic [can_mode_pkg::SJW_FIELD_W-1:0] jump_width_field_i,
    input wire logic cpu_stop_mode_i,
    input wire logic cpu_wait_mode_i,
    input wire logic oscillator_output_clock_i,
    input wire logic system_bus_clock_i,
    input wire logic bus_receive_pin_i,
    input wire logic engine_tx_bit_i,
    input wire logic frame_active_i,
    input wire logic tx_pending_i,
    input wire logic eof_valid_i,
    input wire logic bus_off_i,
    input wire logic copy_req_i,
    input wire logic abort_req_i,
    input wire logic tx_start_req_i,
    output logic sleep_acknowledge_flag_o,
    output logic soft_reset_mode_o,
    output logic power_down_o,
    output logic reg_access_en_o,
    output logic config_write_en_o,
    output logic engine_run_o,
    output logic engine_online_o,
    output logic engine_halt_o,
    output logic bus_transmit_pin_o,
    output logic wakeup_o,
    output logic bit_start_o,
    output logic sample_point_o,
    output logic rx_level_o,
    output logic copy_go_o,
    output logic abort_go_o,
    output logic tx_start_go_o,
    output logic recovery_done_o,
    output logic timestamp_pulse_o,
    output logic capture_ch4_o,
    output logic capture_ch5_o
);
    import can_mode_pkg::*;

    // Prescaler must reach the slowest rate with the longest bit
    localparam int MAX_TQ_BIT = SYNC_SEG_TQ + SEG1_MAX_TQ + SEG2_MAX_TQ;
    localparam int MIN_TQ_BIT = SYNC_SEG_TQ + SEG1_MIN_TQ + SEG2_MIN_TQ;
    generate
        if ((2 ** PRESC_W) * MAX_TQ_BIT < CLK_HZ / MIN_RATE_BPS) begin : g_presc_chk
            $error("prescaler too narrow for slowest rate");
        end
        if (CLK_HZ / MAX_RATE_BPS < MIN_TQ_BIT) begin : g_rate_chk
            $error("clock too slow for fastest rate");
        end
        if (CONTROLLER_INDEX < 0 || CONTROLLER_INDEX > 1) begin : g_idx_chk
            $error("controller index must be 0 or 1");
        end
    endgenerate

    mode_e mode;
    mode_e next_mode;
    logic pd_req;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic rx_lvl;
    logic [5:0] wake_cnt;
    logic wake_evt;
    logic [SEG1_FIELD_W-1:0] seg1_cfg;
    logic [SEG2_FIELD_W-1:0] seg2_cfg;
    logic [SJW_FIELD_W-1:0] sjw_cfg;
    logic [PRESC_W-1:0] presc_cfg;
    logic origin_cfg;
    logic filter_cfg;
    logic src_tick;
    logic [PRESC_W-1:0] presc_cnt;
    logic tq_tick;
    logic run;
    logic hard_sync;
    logic bit_start;
    logic sample;
    logic [3:0] idle_run;
    logic [3:0] rec_run;
    logic [7:0] rec_seq;
    logic asleep;
    logic copy_pend;
    logic abort_pend;
    logic tx_pend;
    logic ts_arm;

    // Power-down follows the processor low-power state
    assign pd_req = cpu_stop_mode_i | (cpu_wait_mode_i & stop_in_wait_bit_i);

    // Receive pin synchroniser, change taken when stages two and three agree
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_lvl <= 1'b1;
        end else begin
            rx_s1 <= bus_receive_pin_i;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_lvl <= rx_s3;
            end
        end
    end

    // Dominant level while asleep wakes the controller, optionally filtered
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_cnt <= '0;
        end else if (mode != MODE_SLEEP || rx_lvl == RECESSIVE) begin
            wake_cnt <= '0;
        end else if (wake_cnt != 6'h3f) begin
            wake_cnt <= wake_cnt + 6'h01;
        end
    end
    assign wake_evt = (rx_lvl != RECESSIVE)
        && (!filter_cfg || wake_cnt >= 6'(WAKE_FILTER_CYC - 1));

    // Configuration shadows load only under soft reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seg1_cfg <= '0;
            seg2_cfg <= '0;
            sjw_cfg <= '0;
            presc_cfg <= '0;
            origin_cfg <= 1'b0;
            filter_cfg <= 1'b0;
        end else if (config_write_en_o) begin
            seg1_cfg <= first_phase_length_field_i;
            seg2_cfg <= second_phase_length_field_i;
            sjw_cfg <= jump_width_field_i;
            presc_cfg <= prescaler_field_i;
            origin_cfg <= clock_origin_select_i;
            filter_cfg <= wakeup_filter_select_i;
        end
    end

    // Mode sequencing; power-down preempts everything, soft reset everything but power-down
    always_comb begin
        next_mode = mode;
        if (pd_req) begin
            next_mode = MODE_POWER_DOWN;
        end else if (soft_reset_request_bit_i) begin
            next_mode = MODE_SOFT_RESET;
        end else begin
            case (mode)
                MODE_NORMAL: begin
                    if (sleep_request_bit_i) begin
                        next_mode = MODE_SLEEP_PEND;
                    end
                end
                MODE_SLEEP_PEND: begin
                    if (!sleep_request_bit_i) begin
                        next_mode = MODE_NORMAL;
                    end else if (!frame_active_i && !tx_pending_i) begin
                        next_mode = MODE_SLEEP;
                    end
                end
                MODE_SLEEP: begin
                    if (wake_evt || !sleep_request_bit_i) begin
                        next_mode = MODE_WAKE_SYNC;
                    end
                end
                MODE_WAKE_SYNC: begin
                    if (sample && rx_lvl == RECESSIVE
                        && idle_run == 4'(IDLE_RUN_BITS - 1)) begin
                        next_mode = MODE_NORMAL;
                    end
                end
                MODE_SOFT_RESET: begin
                    next_mode = MODE_WAKE_SYNC;
                end
                MODE_POWER_DOWN: begin
                    next_mode = MODE_WAKE_SYNC;
                end
                default: begin
                    next_mode = MODE_SOFT_RESET;
                end
            endcase
        end
    end

    // Mode register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode <= MODE_SOFT_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    // Mode status and engine control
    assign asleep = (mode == MODE_SLEEP) || (mode == MODE_POWER_DOWN);
    assign run = (mode == MODE_NORMAL) || (mode == MODE_SLEEP_PEND)
        || (mode == MODE_WAKE_SYNC);
    assign engine_run_o = run;
    assign engine_online_o = (mode == MODE_NORMAL) || (mode == MODE_SLEEP_PEND);
    assign sleep_acknowledge_flag_o = (mode == MODE_SLEEP);
    assign soft_reset_mode_o = (mode == MODE_SOFT_RESET);
    assign power_down_o = (mode == MODE_POWER_DOWN);
    assign reg_access_en_o = (mode != MODE_POWER_DOWN);
    assign config_write_en_o = soft_reset_request_bit_i && reg_access_en_o;

    // Halt pulse and transmit pin
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            engine_halt_o <= 1'b0;
            wakeup_o <= 1'b0;
            bus_transmit_pin_o <= RECESSIVE;
        end else begin
            engine_halt_o <= (next_mode == MODE_SOFT_RESET || next_mode == MODE_POWER_DOWN)
                && run;
            wakeup_o <= (mode == MODE_SLEEP) && (next_mode == MODE_WAKE_SYNC);
            if (next_mode == MODE_NORMAL || next_mode == MODE_SLEEP_PEND) begin
                bus_transmit_pin_o <= engine_tx_bit_i;
            end else begin
                bus_transmit_pin_o <= RECESSIVE;
            end
        end
    end

    // Source clock selection and quantum prescaler
    assign src_tick = (HAS_CLOCK_GEN && origin_cfg)
        ? system_bus_clock_i : oscillator_output_clock_i;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            presc_cnt <= '0;
            tq_tick <= 1'b0;
        end else begin
            tq_tick <= 1'b0;
            if (!run) begin
                presc_cnt <= '0;
            end else if (src_tick) begin
                if (presc_cnt >= presc_cfg) begin
                    presc_cnt <= '0;
                    tq_tick <= 1'b1;
                end else begin
                    presc_cnt <= presc_cnt + 1'b1;
                end
            end
        end
    end

    // Hard sync on each quantum the bus is dominant outside a frame, once a recessive sample point has been counted
    assign hard_sync = !frame_active_i && !rx_lvl && (idle_run != 4'h0);

    bit_timing_unit u_bit_timing (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(run),
        .tq_tick_i(tq_tick),
        .rx_i(rx_lvl),
        .hard_sync_i(hard_sync),
        .seg1_field_i(seg1_cfg),
        .seg2_field_i(seg2_cfg),
        .sjw_field_i(sjw_cfg),
        .bit_start_o(bit_start),
        .sample_o(sample)
    );
    assign bit_start_o = bit_start;
    assign sample_point_o = sample;
    assign rx_level_o = rx_lvl;

    // Consecutive recessive bits for resynchronisation after wake-up
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            idle_run <= '0;
        end else if (!run) begin
            idle_run <= '0;
        end else if (sample) begin
            if (rx_lvl != RECESSIVE || idle_run == 4'(IDLE_RUN_BITS - 1)) begin
                idle_run <= '0;
            end else begin
                idle_run <= idle_run + 4'h1;
            end
        end
    end

    // Bus-off recovery count; frozen, not cleared, while asleep
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rec_run <= '0;
            rec_seq <= '0;
            recovery_done_o <= 1'b0;
        end else begin
            recovery_done_o <= 1'b0;
            if (!bus_off_i || mode == MODE_SOFT_RESET) begin
                rec_run <= '0;
                rec_seq <= '0;
            end else if (sample && engine_online_o) begin
                if (rx_lvl != RECESSIVE) begin
                    rec_run <= '0;
                end else if (rec_run == 4'(IDLE_RUN_BITS - 1)) begin
                    rec_run <= '0;
                    if (rec_seq == 8'(BUSOFF_SEQS - 1)) begin
                        rec_seq <= '0;
                        recovery_done_o <= 1'b1;
                    end else begin
                        rec_seq <= rec_seq + 8'h01;
                    end
                end else begin
                    rec_run <= rec_run + 4'h1;
                end
            end
        end
    end

    // Deferred buffer copy, abort and transmit start across sleep
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            copy_pend <= 1'b0;
            abort_pend <= 1'b0;
            tx_pend <= 1'b0;
            copy_go_o <= 1'b0;
            abort_go_o <= 1'b0;
            tx_start_go_o <= 1'b0;
        end else if (asleep) begin
            copy_pend <= copy_pend | copy_req_i;
            abort_pend <= abort_pend | abort_req_i;
            tx_pend <= tx_pend | tx_start_req_i;
            copy_go_o <= 1'b0;
            abort_go_o <= 1'b0;
            tx_start_go_o <= 1'b0;
        end else begin
            copy_go_o <= copy_pend | copy_req_i;
            abort_go_o <= abort_pend | abort_req_i;
            tx_start_go_o <= tx_pend | tx_start_req_i;
            copy_pend <= 1'b0;
            abort_pend <= 1'b0;
            tx_pend <= 1'b0;
        end
    end

    // Timestamp pulse spans exactly one bit time after a good end of frame
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ts_arm <= 1'b0;
            timestamp_pulse_o <= 1'b0;
        end else if (!run) begin
            ts_arm <= 1'b0;
            timestamp_pulse_o <= 1'b0;
        end else begin
            if (eof_valid_i) begin
                ts_arm <= 1'b1;
            end else if (bit_start) begin
                ts_arm <= 1'b0;
            end
            if (bit_start) begin
                timestamp_pulse_o <= ts_arm;
            end
        end
    end

    // Link to the capture timer
    assign capture_ch4_o = timestamp_link_enable_i && timestamp_pulse_o
        && (CONTROLLER_INDEX + TS_CH_FIRST == TS_CH_FIRST);
    assign capture_ch5_o = timestamp_link_enable_i && timestamp_pulse_o
        && (CONTROLLER_INDEX + TS_CH_FIRST == TS_CH_SECOND);
endmodule : can_mode_timestamp_bit_timing

// [bench/can_mode_props.sv]
// Port assertions for the mode, timestamp and bit-timing block
`timescale 1ns/100ps
module can_mode_props #(
    parameter int CONTROLLER_INDEX = 0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic soft_reset_request_bit_i,
    input wire logic sleep_request_bit_i,
    input wire logic stop_in_wait_bit_i,
    input wire logic timestamp_link_enable_i,
    input wire logic cpu_stop_mode_i,
    input wire logic cpu_wait_mode_i,
    input wire logic sleep_acknowledge_flag_o,
    input wire logic soft_reset_mode_o,
    input wire logic power_down_o,
    input wire logic reg_access_en_o,
    input wire logic config_write_en_o,
    input wire logic engine_run_o,
    input wire logic engine_halt_o,
    input wire logic bus_transmit_pin_o,
    input wire logic bit_start_o,
    input wire logic timestamp_pulse_o,
    input wire logic capture_ch4_o,
    input wire logic capture_ch5_o
);
    logic pd_cond;
    logic sr_cond;
    // Processor low-power demand, and a soft reset request that it outranks
    assign pd_cond = cpu_stop_mode_i || (cpu_wait_mode_i && stop_in_wait_bit_i);
    assign sr_cond = soft_reset_request_bit_i && !pd_cond;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // Mode control
    pd_entry_a: assert property (pd_cond |=> power_down_o) else $error("no power-down");
    pd_halt_a: assert property (
        $rose(power_down_o) |-> !engine_run_o && (engine_halt_o || !$past(engine_run_o)))
        else $error("traffic not stopped");
    pd_pin_a: assert property (
        power_down_o ##1 power_down_o |-> bus_transmit_pin_o) else $error("pin dominant");
    pd_lock_a: assert property (
        power_down_o |-> !reg_access_en_o && !config_write_en_o) else $error("access open");
    sr_halt_a: assert property (
        sr_cond |=> soft_reset_mode_o && !engine_run_o) else $error("engine not halted");
    cfg_lock_a: assert property (
        config_write_en_o |-> soft_reset_request_bit_i && !power_down_o) else $error("cfg open");
    ack_cause_a: assert property (
        $rose(sleep_acknowledge_flag_o) |-> $past(sleep_request_bit_i, 2) && !engine_run_o)
        else $error("ack without request");
    // Timestamp pulse
    ts_rise_a: assert property ($rose(timestamp_pulse_o) |-> $past(bit_start_o))
        else $error("pulse off bit start");
    ts_fall_a: assert property (
        $fell(timestamp_pulse_o) |-> $past(bit_start_o) || !engine_run_o || !$past(engine_run_o))
        else $error("pulse length");
    ts_link_a: assert property ({capture_ch5_o, capture_ch4_o} ==
        ((timestamp_pulse_o && timestamp_link_enable_i) ? (CONTROLLER_INDEX == 0 ? 2'h1 : 2'h2)
        : 2'h0)) else $error("capture routing");
    // Main scenarios reached
    pd_c: cover property ($rose(power_down_o));
    ack_c: cover property ($rose(sleep_acknowledge_flag_o));
    ts_c: cover property (capture_ch4_o || capture_ch5_o);
endmodule : can_mode_props

// [bench/can_bus_partner.sv]
// Bus transceiver model: wired-AND bus resting recessive
`timescale 1ns/100ps
module can_bus_partner (
    input wire logic tx_i,
    input wire logic dom_i,
    output logic rx_o
);
    // Any node driving dominant pulls the bus low
    assign rx_o = tx_i & ~dom_i;
endmodule : can_bus_partner

// [bench/testbench.sv]
// Self-checking bench for the mode, timestamp and bit-timing block
`timescale 1ns/100ps
`define CK(nm, e, s) begin num_checks++; if ((e) !== (s)) begin n_errors++; \
$display("BAD %s exp %0h got %0h", nm, e, s); end end
module testbench;
    logic clk_i = 1'b0, rst_b_i = 1'b0, srr = 1'b1, slp = 1'b0, siw = 1'b0, wfs = 1'b0;
    logic tle = 1'b0, cos = 1'b1, stp = 1'b0, wai = 1'b0, etx = 1'b1, fa = 1'b0, tp = 1'b0;
    logic eof = 1'b0, cp = 1'b0, ab = 1'b0, txs = 1'b0, dom = 1'b0, rx;
    logic ack, pd, acc, onl, pin, wk, bs, sp, cpg, abg, txg, tsp, ch4, ch5;
    logic [3:0] gos = 4'h0;
    int s1, s2, jw, p, c, nsp, cyc = 0, n_errors = 0, num_checks = 0, seed = 16148;
    can_bus_partner i_bus (.tx_i(pin), .dom_i(dom), .rx_o(rx));
    can_mode_timestamp_bit_timing i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .soft_reset_request_bit_i(srr), .sleep_request_bit_i(slp), .stop_in_wait_bit_i(siw),
        .wakeup_filter_select_i(wfs), .timestamp_link_enable_i(tle), .clock_origin_select_i(cos),
        .prescaler_field_i(p[6:0]), .first_phase_length_field_i(s1[3:0]),
        .second_phase_length_field_i(s2[2:0]), .jump_width_field_i(jw[1:0]),
        .cpu_stop_mode_i(stp), .cpu_wait_mode_i(wai), .oscillator_output_clock_i(cyc[0]),
        .system_bus_clock_i(1'b1), .bus_receive_pin_i(rx), .engine_tx_bit_i(etx),
        .frame_active_i(fa), .tx_pending_i(tp), .eof_valid_i(eof), .bus_off_i(1'b0),
        .copy_req_i(cp), .abort_req_i(ab), .tx_start_req_i(txs),
        .sleep_acknowledge_flag_o(ack), .soft_reset_mode_o(), .power_down_o(pd),
        .reg_access_en_o(acc), .config_write_en_o(), .engine_run_o(), .engine_online_o(onl),
        .engine_halt_o(), .bus_transmit_pin_o(pin), .wakeup_o(wk), .bit_start_o(bs),
        .sample_point_o(sp), .rx_level_o(), .copy_go_o(cpg), .abort_go_o(abg),
        .tx_start_go_o(txg), .recovery_done_o(), .timestamp_pulse_o(tsp),
        .capture_ch4_o(ch4), .capture_ch5_o(ch5));
    always #25 clk_i = ~clk_i;
    // Sticky record of released work and wake pulses; run limit
    always @(posedge clk_i) begin
        gos <= gos | {wk, cpg, abg, txg};
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tk
    // Waits until the engine is back on the bus, counting sample points
    task automatic wo();
        for (int k = 0; k < 9000 && onl !== 1'b1; k++) begin
            tk(1);
            nsp += int'(sp);
        end
    endtask : wo
    function automatic int exp_bit();
        return (s1 + s2 + 3) * (p + 1) * (cos ? 1 : 2);
    endfunction : exp_bit
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        tk(5);
        rst_b_i = 1'b1;
        // Timing set-ups: shortest, longest, random; each with a timestamp
        for (int i = 0; i < 3; i++) begin
            slp = 1'b1;
            tk(3);
            srr = 1'b1;
            s1 = (i == 0) ? 3 : (i == 1) ? 15 : 3 + $unsigned($random(seed)) % 13;
            s2 = (i == 0) ? 1 : (i == 1) ? 7 : 1 + $unsigned($random(seed)) % 7;
            jw = $unsigned($random(seed)) % 4;
            p = $unsigned($random(seed)) % 4;
            {cos, tle, wfs} = {i[0], i[0], i == 2};
            tk(3);
            {srr, slp} = 2'h0;
            nsp = 0;
            wo();
            `CK("idle run", 1'b1, nsp >= 11)
            for (int k = 0; k < 999 && bs !== 1'b1; k++) tk(1);
            c = 0;
            do begin
                tk(1);
                c++;
            end while (bs !== 1'b1 && c < 999);
            `CK("bit cycles", exp_bit(), c)
            eof = 1'b1;
            tk(1);
            eof = 1'b0;
            for (int k = 0; k < 999 && tsp !== 1'b1; k++) tk(1);
            `CK("ch4", tle, ch4)
            `CK("ch5", 1'b0, ch5)
            for (c = 0; c < 999 && tsp === 1'b1; c++) tk(1);
            `CK("stamp cycles", exp_bit(), c)
            $display("timing set %0d done", i);
        end
        // Sleep refused while busy; deferred work released on wake
        slp = 1'b1;
        for (int j = 1; j < 3; j++) begin
            {fa, tp} = j[1:0];
            tk(6);
            `CK("ack busy", 1'b0, ack)
        end
        {fa, tp} = 2'h0;
        tk(3);
        `CK("ack", 1'b1, ack)
        {cp, ab, txs} = 3'h7;
        tk(1);
        {cp, ab, txs, gos} = 7'h0;
        tk(4);
        `CK("held work", 4'h0, gos)
        slp = 1'b0;
        tk(6);
        `CK("released work", 4'hf, gos)
        // Short dominant glitch filtered, long one wakes
        wo();
        slp = 1'b1;
        tk(4);
        dom = 1'b1;
        tk(20);
        dom = 1'b0;
        tk(40);
        `CK("glitch", 1'b1, ack)
        dom = 1'b1;
        tk(60);
        `CK("bus wake", 1'b0, ack)
        {slp, dom} = 2'h0;
        $display("sleep tests done");
        // Processor stop, wait with and without stop-in-wait, after random traffic
        for (int j = 0; j < 3; j++) begin
            wo();
            slp = (j == 1);
            repeat (20) begin
                etx = 1'($random(seed));
                tk(1);
            end
            {stp, wai, siw} = (j == 0) ? 3'h4 : (j == 1) ? 3'h3 : 3'h2;
            tk(3);
            `CK("power-down", j < 2, pd)
            `CK("access", j == 2, acc)
            `CK("tx pin", 1'b1, pin || j == 2)
            {stp, wai, siw, etx, slp} = 5'h2;
        end
        $display("power-down tests done");
        print_verdict();
    end
endmodule : testbench
bind can_mode_timestamp_bit_timing can_mode_props #(.CONTROLLER_INDEX(CONTROLLER_INDEX)) i_props (
    .clk_i, .rst_b_i, .soft_reset_request_bit_i, .sleep_request_bit_i, .stop_in_wait_bit_i,
    .timestamp_link_enable_i, .cpu_stop_mode_i, .cpu_wait_mode_i, .sleep_acknowledge_flag_o,
    .soft_reset_mode_o, .power_down_o, .reg_access_en_o, .config_write_en_o, .engine_run_o,
    .engine_halt_o, .bus_transmit_pin_o, .bit_start_o, .timestamp_pulse_o, .capture_ch4_o,
    .capture_ch5_o);
